// >>> include/dcf_defines.svh
// Purpose: Constants for the dual-clock FIFO pin-level controller.
// Assumes: Included by bare name; definitions only.
// Notes:   Pin bundle layout matches the synchroniser vector in dcf_ctrl.
`ifndef DCF_DEFINES_SVH
`define DCF_DEFINES_SVH

// ==========================================================================
// Geometry
`define DCF_DATA_W        18
`define DCF_DEPTH_DEFAULT 8192
`define DCF_STAGE_DEPTH   32

// ==========================================================================
// Synchronised pin bundle positions
`define DCF_PIN_W         28
`define DCF_POS_WCLK      27
`define DCF_POS_RCLK      26
`define DCF_POS_WEN       25
`define DCF_POS_REN       24
`define DCF_POS_LOAD      23
`define DCF_POS_FLRT      22
`define DCF_POS_WTOK      21
`define DCF_POS_RTOK      20
`define DCF_POS_OE        19
`define DCF_POS_SYNC      18
`define DCF_PIN_IDLE      28'h3FC0000

// ==========================================================================
// Reset values
`define DCF_AE_OFF_RST    18'h0007F
`define DCF_AF_OFF_RST    18'h0007F
`define DCF_DATA_RST      18'h00000

`endif

// >>> include/dcf_pkg.sv
// Purpose: Shared types for the dual-clock FIFO controller.
// Assumes: Referenced with explicit package scope only.
// Notes:   Token states are one-hot.
package dcf_pkg;

  // ========================================================================
  // Cascade token ownership
  typedef enum logic [1:0] {
    TOK_WAIT = 2'b01,
    TOK_HOLD = 2'b10
  } dcf_token_type;

endpackage

// >>> include/dcf_stream_if.sv
// Purpose: Valid/ready word stream between controller and staging FIFO.
// Assumes: Same clock on both ends.
// Notes:   A word moves when valid and ready are both high.
`timescale 1ns/1ns
interface dcf_stream_if #(parameter int W = 18) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  // ========================================================================
  // Producer and consumer views
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> core/dcf_stage_fifo.sv
// Purpose: Parameterised staging FIFO with valid/ready on both sides.
// Assumes: Synchronous active-high reset.
// Notes:   Extra pointer bit separates full from empty.
`timescale 1ns/1ns
module dcf_stage_fifo #(
  parameter int W = 18,
  parameter int D = 32
) (
  input  wire logic                 mclk,
  input  wire logic                 reset,
  dcf_stream_if.snk                 inPort,
  dcf_stream_if.src                 outPort,
  output      logic [$clog2(D):0]   level
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0]  wrPtr_reg;
  logic [AW:0]  wrPtr_next;
  logic [AW:0]  rdPtr_reg;
  logic [AW:0]  rdPtr_next;
  logic         push;
  logic         pop;

  // ========================================================================
  // Flags and handshakes
  assign level         = wrPtr_reg - rdPtr_reg;
  assign inPort.ready  = level != (AW + 1)'(D);
  assign outPort.valid = level != '0;
  assign outPort.data  = mem[rdPtr_reg[AW-1:0]];
  assign push          = inPort.valid & inPort.ready;
  assign pop           = outPort.valid & outPort.ready;

  // Pointer next values
  always_comb begin
    wrPtr_next = push ? wrPtr_reg + 1'b1 : wrPtr_reg;
    rdPtr_next = pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
  end

  // Pointer and storage registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
    end
    if (push) begin
      mem[wrPtr_reg[AW-1:0]] <= inPort.data;
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  stage_level_a: assert property (
    (push && !pop) |=> level == $past(level) + 1'b1)
    else $error("staging level did not rise on push");
  stage_bound_a: assert property (level <= (AW + 1)'(D))
    else $error("staging level above depth");
  stage_full_c: cover property (!inPort.ready);
endmodule

// >>> core/dcf_ctrl.sv
// Purpose: Pin-level controller of an 18-bit dual-clock FIFO with flags.
// Assumes: Write and read clocks arrive as pins sampled on mclk.
// Notes:   Pins pass two flops; clock edges are found on the third.
//
// Summary of operation
// - Read edge with read enabled and data present outputs oldest word.
// - Read edge while loading outputs the flag-offset register instead.
// - Uncascaded, the dual pin shows active-low half full.
// - Cascaded, the dual pin carries the write token to the next device.
// - Empty flag updated on read edges only, low if the buffer is then empty.
// - Full flag updated on write edges only, low if the buffer is then full.
// - Almost-empty low when stored count is at or below its offset.
// - Almost-empty follows count freely if strap high, else on read edges.
// - Almost-full low when free space is at or below its offset.
// - Almost-full follows count freely if strap high, else on write edges.
// - Load low steers data in and out to the offset register.
// - In a cascade only the first-load-low device starts with the tokens.
// - Uncascaded, a rewind strobe restarts reading from the beginning.
// - Read token passes on through the read token output when cascaded.
// - Reset empties the buffer, clears pointers, sets empty flag values.
// - Output enable low drives data outputs, high releases them.
// - Write edge with write enabled and room stores the input word.
// - Write edge while loading stores the word into the offset register.
`timescale 1ns/1ns
`include "dcf_defines.svh"
module dcf_ctrl #(
  parameter int DW    = `DCF_DATA_W,
  parameter int DEPTH = `DCF_DEPTH_DEFAULT,
  parameter int SD    = `DCF_STAGE_DEPTH
) (
  input  wire logic          mclk,
  input  wire logic          reset,
  input  wire logic          wrClk,
  input  wire logic          rdClk,
  input  wire logic          wrEnN,
  input  wire logic          rdEnN,
  input  wire logic [DW-1:0] dataIn,
  input  wire logic          offset_load_n,
  input  wire logic          first_load_rewind_n,
  input  wire logic          wr_token_in_n,
  input  wire logic          rd_token_in_n,
  input  wire logic          outEnN,
  input  wire logic          flag_sync_sel_n,
  input  wire logic          cascadeMode,
  output      logic [DW-1:0] dataOut,
  output      logic          dataOutEn,
  output      logic          empty_n,
  output      logic          full_n,
  output      logic          almost_empty_n,
  output      logic          almost_full_n,
  output      logic          wr_token_out_half_full_n,
  output      logic          rd_token_out_n
);
  localparam int AW   = $clog2(DEPTH);
  localparam int CW   = AW + 2;
  localparam int SW   = $clog2(SD) + 1;
  localparam int HALF = DEPTH / 2;

  // ========================================================================
  // Pin synchronisers
  logic [`DCF_PIN_W-1:0] pinRaw;
  logic [`DCF_PIN_W-1:0] sync1_reg;
  logic [`DCF_PIN_W-1:0] sync2_reg;
  logic [`DCF_PIN_W-1:0] prev_reg;

  assign pinRaw = {wrClk, rdClk, wrEnN, rdEnN, offset_load_n,
                   first_load_rewind_n, wr_token_in_n, rd_token_in_n,
                   outEnN, flag_sync_sel_n, dataIn};

  // Two-flop capture plus edge history, free running through reset
  // so the strap is real at release and no false edge follows it
  always_ff @(posedge mclk) begin
    sync1_reg <= pinRaw;
    sync2_reg <= sync1_reg;
    prev_reg  <= sync2_reg;
  end

  // ========================================================================
  // Decoded pin events
  logic          wrEdge;
  logic          rdEdge;
  logic          wrReq;
  logic          rdReq;
  logic          loading;
  logic          asyncMode;
  logic          rewindStrobe;
  logic          wrTokIn;
  logic          rdTokIn;
  logic [DW-1:0] dataSync;

  // Edges and levels from the synchronised bundle
  always_comb begin
    wrEdge    = sync2_reg[`DCF_POS_WCLK] & ~prev_reg[`DCF_POS_WCLK];
    rdEdge    = sync2_reg[`DCF_POS_RCLK] & ~prev_reg[`DCF_POS_RCLK];
    wrReq     = wrEdge & ~sync2_reg[`DCF_POS_WEN];
    rdReq     = rdEdge & ~sync2_reg[`DCF_POS_REN];
    loading   = ~sync2_reg[`DCF_POS_LOAD];
    asyncMode = sync2_reg[`DCF_POS_SYNC];
    rewindStrobe = ~cascadeMode & sync2_reg[`DCF_POS_FLRT]
                   & ~prev_reg[`DCF_POS_FLRT];
    wrTokIn   = ~sync2_reg[`DCF_POS_WTOK] & prev_reg[`DCF_POS_WTOK];
    rdTokIn   = ~sync2_reg[`DCF_POS_RTOK] & prev_reg[`DCF_POS_RTOK];
    dataSync  = sync2_reg[DW-1:0];
  end

  // ========================================================================
  // Staging FIFO in the write path
  dcf_stream_if #(.W(DW)) stageIn ();
  dcf_stream_if #(.W(DW)) stageOut ();
  logic [SW-1:0] stageLevel;

  dcf_stage_fifo #(.W(DW), .D(SD)) u_stage (
    .mclk    (mclk),
    .reset   (reset),
    .inPort  (stageIn),
    .outPort (stageOut),
    .level   (stageLevel)
  );

  // ========================================================================
  // Main storage and pointers
  logic [DW-1:0]  mem [DEPTH];
  logic [AW:0]    wrPtr_reg;
  logic [AW:0]    wrPtr_next;
  logic [AW:0]    rdPtr_reg;
  logic [AW:0]    rdPtr_next;
  logic [AW:0]    mainCount;
  logic [AW:0]    mainCountNext;
  logic [CW-1:0]  totalNext;
  logic           push;
  logic           pop;
  logic           drain;
  logic           canWrite;
  logic           canRead;
  dcf_pkg::dcf_token_type wrTok_reg;
  dcf_pkg::dcf_token_type wrTok_next;
  dcf_pkg::dcf_token_type rdTok_reg;
  dcf_pkg::dcf_token_type rdTok_next;
  logic           armed_reg;

  assign mainCount = wrPtr_reg - rdPtr_reg;

  // Transfer decisions and pointer next values
  always_comb begin
    canWrite = ~cascadeMode | (wrTok_reg == dcf_pkg::TOK_HOLD);
    canRead  = ~cascadeMode | (rdTok_reg == dcf_pkg::TOK_HOLD);
    push = wrReq & ~loading & canWrite & stageIn.ready
           & (32'(mainCount) + 32'(stageLevel) < 32'(DEPTH));
    pop   = rdReq & ~loading & canRead & (mainCount != '0);
    drain = stageOut.valid & (mainCount != (AW + 1)'(DEPTH));
    stageIn.valid  = push;
    stageIn.data   = dataSync;
    stageOut.ready = drain;
    wrPtr_next = drain ? wrPtr_reg + 1'b1 : wrPtr_reg;
    rdPtr_next = pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
    if (rewindStrobe) begin
      rdPtr_next = '0;
    end
    mainCountNext = wrPtr_next - rdPtr_next;
    totalNext = CW'(mainCountNext) + CW'(stageLevel) + CW'(push)
                - CW'(drain);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
    end
    if (drain) begin
      mem[wrPtr_reg[AW-1:0]] <= stageOut.data;
    end
  end

  // ========================================================================
  // Cascade tokens
  logic wrTokPass;
  logic rdTokPass;

  // strap caught right after reset release
  always_comb begin
    wrTokPass  = cascadeMode & push & (32'(totalNext) == 32'(DEPTH));
    rdTokPass  = cascadeMode & pop & (totalNext == '0);
    wrTok_next = wrTok_reg;
    rdTok_next = rdTok_reg;
    if (armed_reg) begin
      wrTok_next = sync2_reg[`DCF_POS_FLRT] ? dcf_pkg::TOK_WAIT
                                            : dcf_pkg::TOK_HOLD;
      rdTok_next = wrTok_next;
    end else begin
      case (wrTok_reg)
        dcf_pkg::TOK_HOLD: begin
          if (wrTokPass) wrTok_next = dcf_pkg::TOK_WAIT;
        end
        dcf_pkg::TOK_WAIT: begin
          if (wrTokIn) wrTok_next = dcf_pkg::TOK_HOLD;
        end
        default: wrTok_next = dcf_pkg::TOK_WAIT;
      endcase
      case (rdTok_reg)
        dcf_pkg::TOK_HOLD: begin
          if (rdTokPass) rdTok_next = dcf_pkg::TOK_WAIT;
        end
        dcf_pkg::TOK_WAIT: begin
          if (rdTokIn) rdTok_next = dcf_pkg::TOK_HOLD;
        end
        default: rdTok_next = dcf_pkg::TOK_WAIT;
      endcase
    end
  end

  // Token registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      wrTok_reg <= dcf_pkg::TOK_WAIT;
      rdTok_reg <= dcf_pkg::TOK_WAIT;
      armed_reg <= 1'b1;
    end else begin
      wrTok_reg <= wrTok_next;
      rdTok_reg <= rdTok_next;
      armed_reg <= 1'b0;
    end
  end

  // ========================================================================
  // Offset registers and output data
  logic [DW-1:0] aeOff_reg;
  logic [DW-1:0] aeOff_next;
  logic [DW-1:0] afOff_reg;
  logic [DW-1:0] afOff_next;
  logic          offWrSel_reg;
  logic          offWrSel_next;
  logic          offRdSel_reg;
  logic          offRdSel_next;
  logic [DW-1:0] dataOut_reg;
  logic [DW-1:0] dataOut_next;
  logic          dataOutEn_reg;
  logic          dataOutEn_next;

  // Offset access, data out and drive enable
  always_comb begin
    aeOff_next    = aeOff_reg;
    afOff_next    = afOff_reg;
    offWrSel_next = offWrSel_reg;
    offRdSel_next = offRdSel_reg;
    dataOut_next  = dataOut_reg;
    if (wrReq & loading) begin
      if (offWrSel_reg) afOff_next = dataSync;
      else aeOff_next = dataSync;
      offWrSel_next = ~offWrSel_reg;
    end
    if (rdReq & loading) begin
      dataOut_next  = offRdSel_reg ? afOff_reg : aeOff_reg;
      offRdSel_next = ~offRdSel_reg;
    end else if (pop) begin
      dataOut_next = mem[rdPtr_reg[AW-1:0]];
    end
    dataOutEn_next = ~sync2_reg[`DCF_POS_OE];
  end

  // Offset and output registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      aeOff_reg     <= `DCF_AE_OFF_RST;
      afOff_reg     <= `DCF_AF_OFF_RST;
      offWrSel_reg  <= 1'b0;
      offRdSel_reg  <= 1'b0;
      dataOut_reg   <= `DCF_DATA_RST;
      dataOutEn_reg <= 1'b0;
    end else begin
      aeOff_reg     <= aeOff_next;
      afOff_reg     <= afOff_next;
      offWrSel_reg  <= offWrSel_next;
      offRdSel_reg  <= offRdSel_next;
      dataOut_reg   <= dataOut_next;
      dataOutEn_reg <= dataOutEn_next;
    end
  end

  // ========================================================================
  // Status flags
  logic empty_reg;
  logic empty_next;
  logic full_reg;
  logic full_next;
  logic aeFlag_reg;
  logic aeFlag_next;
  logic afFlag_reg;
  logic afFlag_next;
  logic dual_reg;
  logic dual_next;
  logic rdTokOut_reg;
  logic rdTokOut_next;

  // Flag next values
  always_comb begin
    empty_next = rdEdge ? (mainCountNext != '0) : empty_reg;
    full_next = wrEdge ? (32'(totalNext) < 32'(DEPTH)) : full_reg;
    aeFlag_next = (asyncMode | rdEdge)
                  ? ~(32'(totalNext) <= 32'(aeOff_reg)) : aeFlag_reg;
    afFlag_next = (asyncMode | wrEdge)
                  ? ~(32'(DEPTH) - 32'(totalNext) <= 32'(afOff_reg))
                  : afFlag_reg;
    if (cascadeMode) dual_next = ~wrTokPass;
    else dual_next = ~(32'(totalNext) > 32'(HALF));
    rdTokOut_next = ~rdTokPass;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      empty_reg    <= 1'b0;
      full_reg     <= 1'b1;
      aeFlag_reg   <= 1'b0;
      afFlag_reg   <= 1'b1;
      dual_reg     <= 1'b1;
      rdTokOut_reg <= 1'b1;
    end else begin
      empty_reg    <= empty_next;
      full_reg     <= full_next;
      aeFlag_reg   <= aeFlag_next;
      afFlag_reg   <= afFlag_next;
      dual_reg     <= dual_next;
      rdTokOut_reg <= rdTokOut_next;
    end
  end

  // Outputs straight from flops
  assign dataOut                  = dataOut_reg;
  assign dataOutEn                = dataOutEn_reg;
  assign empty_n                  = empty_reg;
  assign full_n                   = full_reg;
  assign almost_empty_n           = aeFlag_reg;
  assign almost_full_n            = afFlag_reg;
  assign wr_token_out_half_full_n = dual_reg;
  assign rd_token_out_n           = rdTokOut_reg;

  // ========================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  read_advance_a: assert property (
    (pop && !rewindStrobe) |=> rdPtr_reg == $past(rdPtr_reg) + 1'b1)
    else $error("read pointer did not advance");
  offset_read_a: assert property (
    (rdReq && loading) |=>
      dataOut == $past(offRdSel_reg ? afOff_reg : aeOff_reg))
    else $error("offset register not returned");
  half_full_a: assert property (
    (!cascadeMode && $past(!cascadeMode)) |->
      wr_token_out_half_full_n == !($past(32'(totalNext)) > 32'(HALF)))
    else $error("half full flag wrong");
  token_out_a: assert property (
    wrTokPass |=> !wr_token_out_half_full_n ##1 wr_token_out_half_full_n)
    else $error("write token pulse wrong");
  empty_edge_a: assert property (
    $changed(empty_n) |-> $past(rdEdge))
    else $error("empty flag moved off read edge");
  full_edge_a: assert property (
    $changed(full_n) |-> $past(wrEdge))
    else $error("full flag moved off write edge");
  ae_sync_a: assert property (
    ($changed(almost_empty_n) && !$past(asyncMode)) |-> $past(rdEdge))
    else $error("almost empty moved off read edge");
  af_sync_a: assert property (
    ($changed(almost_full_n) && !$past(asyncMode)) |-> $past(wrEdge))
    else $error("almost full moved off write edge");
  offset_load_a: assert property (
    (wrReq && loading && !offWrSel_reg) |=> aeOff_reg == $past(dataSync))
    else $error("almost empty offset not loaded");
  rewind_ptr_a: assert property (
    rewindStrobe |=> rdPtr_reg == '0)
    else $error("rewind did not clear read pointer");
  reset_state_a: assert property (
    disable iff (1'b0) reset |=> (!empty_n && full_n && wrPtr_reg == '0
                                  && rdPtr_reg == '0))
    else $error("reset did not empty the buffer");
  drive_enable_a: assert property (
    $past(!reset) |-> dataOutEn == !$past(sync2_reg[`DCF_POS_OE]))
    else $error("output enable wrong");

  read_word_c: cover property (pop ##[1:20] pop);
  full_reach_c: cover property (!full_n);
  offset_load_c: cover property (wrReq && loading ##[1:40] rdReq && loading);
  rewind_c: cover property (rewindStrobe);
endmodule

// >>> tb/dcf_far_side.sv
// Purpose: Writing and reading master model for the FIFO controller.
// Assumes: Pin clocks are slow against mclk; drives 1 ns after an edge.
// Notes:   Pin clocks stand low between transfers.
`timescale 1ns/1ns
module dcf_far_side (
  input  wire logic        mclk,
  input  wire logic [17:0] dataOut,
  output      logic        wrClk,
  output      logic        rdClk,
  output      logic        wrEnN,
  output      logic        rdEnN,
  output      logic [17:0] dataIn
);
  // ==========================================================================
  // Idle levels at time zero
  initial begin
    wrClk  = 1'b0;
    rdClk  = 1'b0;
    wrEnN  = 1'b1;
    rdEnN  = 1'b1;
    dataIn = 18'h00000;
  end

  // Wait n edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // ==========================================================================
  // setup, edge, hold
  task automatic pulse_wr(input logic en, input logic [17:0] d);
    wrEnN  = ~en;
    dataIn = d;
    tick(4);
    wrClk  = 1'b1;
    tick(4);
    wrClk  = 1'b0;
    wrEnN  = 1'b1;
    dataIn = ~d; // Released bus shows no stale word
    tick(4);
  endtask

  // setup, edge, take data after answer
  task automatic pulse_rd(input logic en, output logic [17:0] q);
    rdEnN = ~en;
    tick(4);
    rdClk = 1'b1;
    tick(4);
    q     = dataOut;
    rdClk = 1'b0;
    rdEnN = 1'b1;
    tick(4);
  endtask
endmodule

// >>> tb/dual_clock_sync_fifo_pin_control_tb.sv
// Purpose: Self-checking bench for the dual-clock FIFO controller.
// Assumes: Standalone use, then one cascaded device; small depth.
// Notes:   Offsets loaded small so every flag boundary is crossed.
`timescale 1ns/1ns
module dual_clock_sync_fifo_pin_control_tb;
  localparam int DEPTH = 64;
  localparam int AEO   = 4;
  localparam int AFO   = 6;
  localparam int LIMIT = 20000;

  logic        mclk;
  logic        reset;
  logic        wrClk;
  logic        rdClk;
  logic        wrEnN;
  logic        rdEnN;
  logic [17:0] dataIn;
  logic [17:0] dataOut;
  logic        offsetLoadN;
  logic        rewindN;
  logic        outEnN;
  logic        syncSelN;
  logic        dataOutEn;
  logic        empty_n;
  logic        full_n;
  logic        almost_empty_n;
  logic        almost_full_n;
  logic        halfFullN;
  logic        rdTokOutN;
  logic        wrTokInN;
  logic        rdTokInN;
  logic        cascade;
  int          wrPulses;
  int          rdPulses;
  logic [17:0] q;
  int          nMismatch;
  int          checks;
  int          cycles;

  // ==========================================================================
  // Clock, timeout
  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      nMismatch = nMismatch + 1;
      close_out();
    end
  end

  // Token pulses seen while cascaded, sampled mid-cycle
  always @(negedge mclk) begin
    if (cascade && !halfFullN) wrPulses <= wrPulses + 1;
    if (!rdTokOutN) rdPulses <= rdPulses + 1;
  end

  // ==========================================================================
  // Design and far side; token inputs held low when not cascaded
  dcf_ctrl #(.DEPTH(DEPTH)) u_dut (
    .mclk(mclk), .reset(reset), .wrClk(wrClk), .rdClk(rdClk),
    .wrEnN(wrEnN), .rdEnN(rdEnN), .dataIn(dataIn),
    .offset_load_n(offsetLoadN), .first_load_rewind_n(rewindN),
    .wr_token_in_n(wrTokInN), .rd_token_in_n(rdTokInN), .outEnN(outEnN),
    .flag_sync_sel_n(syncSelN), .cascadeMode(cascade), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .empty_n(empty_n), .full_n(full_n),
    .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n),
    .wr_token_out_half_full_n(halfFullN), .rd_token_out_n(rdTokOutN)
  );

  dcf_far_side u_far (
    .mclk(mclk), .dataOut(dataOut), .wrClk(wrClk), .rdClk(rdClk),
    .wrEnN(wrEnN), .rdEnN(rdEnN), .dataIn(dataIn)
  );

  // ==========================================================================
  // Compare helpers
  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      nMismatch = nMismatch + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [17:0] pat(input int i);
    return 18'(i * 18'h00A3B + 18'h00015);
  endfunction

  // Full, almost empty, almost full, half full for n words held
  function automatic logic [17:0] flagsExp(input int n);
    return 18'({n < DEPTH, n > AEO, (DEPTH - n) > AFO, n <= DEPTH / 2});
  endfunction

  function automatic logic [17:0] flagsGot();
    return 18'({full_n, almost_empty_n, almost_full_n, halfFullN});
  endfunction

  task automatic reset_check();
    check(18'({empty_n, full_n, almost_empty_n, almost_full_n, halfFullN,
               rdTokOutN}), 18'h00017);
  endtask

  task automatic do_reset();
    reset = 1'b1;
    u_far.tick(6);
    reset_check();
    reset = 1'b0;
    u_far.tick(1);
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checks, nMismatch);
    if (nMismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================================
  // Test sequence
  initial begin
    nMismatch = 0;
    checks = 0;
    cycles = 0;
    wrPulses = 0;
    rdPulses = 0;
    wrTokInN = 1'b0;
    rdTokInN = 1'b0;
    cascade = 1'b0;
    reset = 1'b1;
    offsetLoadN = 1'b1;
    rewindN = 1'b0;
    outEnN = 1'b1;
    syncSelN = 1'b1;
    u_far.tick(1);
    do_reset();
    check(dataOut, 18'h00000);
    check(18'(dataOutEn), 18'h00000);
    outEnN = 1'b0;
    u_far.tick(4);
    check(18'(dataOutEn), 18'h00001);
    outEnN = 1'b1;
    u_far.tick(4);
    check(18'(dataOutEn), 18'h00000);
    outEnN = 1'b0;
    // Offsets loaded and read back
    offsetLoadN = 1'b0;
    u_far.pulse_wr(1'b1, 18'(AEO));
    u_far.pulse_wr(1'b1, 18'(AFO));
    u_far.pulse_rd(1'b1, q);
    check(q, 18'(AEO));
    u_far.pulse_rd(1'b1, q);
    check(q, 18'(AFO));
    offsetLoadN = 1'b1;
    // Fill to full with free-running flags, then one refused write
    for (int i = 0; i < DEPTH; i++) begin
      u_far.pulse_wr(1'b1, pat(i));
      check(flagsGot(), flagsExp(i + 1));
      if (i == 0) check(18'(empty_n), 18'h00000);
    end
    u_far.pulse_wr(1'b1, 18'h3FFFF);
    check(flagsGot(), flagsExp(DEPTH));
    u_far.pulse_rd(1'b0, q);
    check(18'(empty_n), 18'h00001);
    // Drain in order
    for (int i = 0; i < DEPTH; i++) begin
      u_far.pulse_rd(1'b1, q);
      check(q, pat(i));
      check(flagsGot(), flagsExp(DEPTH - 1 - i) & 18'h00007);
      check(18'(full_n), 18'h00000);
      check(18'(empty_n), 18'(i != DEPTH - 1));
    end
    u_far.pulse_rd(1'b1, q);
    check(q, pat(DEPTH - 1));
    // Almost-empty waits for a read edge in synchronous mode
    syncSelN = 1'b0;
    for (int i = 0; i < AEO + 1; i++) u_far.pulse_wr(1'b1, pat(i));
    check(18'(almost_empty_n), 18'h00000);
    u_far.pulse_rd(1'b0, q);
    check(18'(almost_empty_n), 18'h00001);
    // Mid-run reset, then rewind
    do_reset();
    syncSelN = 1'b1;
    for (int i = 0; i < 3; i++) u_far.pulse_wr(1'b1, pat(i));
    u_far.pulse_rd(1'b0, q);
    for (int i = 0; i < 3; i++) begin
      u_far.pulse_rd(1'b1, q);
      check(q, pat(i));
    end
    rewindN = 1'b1;
    u_far.tick(6);
    rewindN = 1'b0;
    u_far.tick(6);
    u_far.pulse_rd(1'b0, q);
    u_far.pulse_rd(1'b1, q);
    check(q, pat(0));
    // Cascade: not the first device, so both tokens start elsewhere
    cascade = 1'b1;
    rewindN = 1'b1;
    wrTokInN = 1'b1;
    rdTokInN = 1'b1;
    do_reset();
    u_far.pulse_wr(1'b1, pat(0));
    u_far.pulse_rd(1'b0, q);
    check(18'(empty_n), 18'h00000);
    wrTokInN = 1'b0;
    rdTokInN = 1'b0;
    u_far.tick(4);
    for (int i = 0; i < DEPTH; i++) u_far.pulse_wr(1'b1, pat(i));
    check(18'(wrPulses), 18'h00001);
    check(18'(full_n), 18'h00000);
    for (int i = 0; i < DEPTH; i++) begin
      u_far.pulse_rd(1'b1, q);
      check(q, pat(i));
    end
    check(18'(rdPulses), 18'h00001);
    close_out();
  end
endmodule
